// *** logic/crdb_top.v ***
`timescale 1ns/10ps
`default_nettype none
`include "crdb_consts.vh"
module crdb_top #(
	parameter RW = 24
) (
	// clock, reset, enable
	input wire clock,
	input wire rst_n,
	input wire ce,
	// serial pins
	input wire sclk,
	input wire cs_n,
	input wire din,
	output wire serial_out_ready_n,
	output wire serial_out_oe_n,
	output wire result_ready_n,
	// conversion results
	input wire conv_valid,
	output wire conv_ready,
	input wire [RW-1:0] conv_data,
	// mode and field options
	input wire direct_mode,
	input wire continuous_mode,
	input wire status_en,
	input wire crc_en,
	input wire [7:0] status_byte,
	// register file access
	output wire [4:0] reg_rd_addr,
	input wire [7:0] reg_rd_data,
	output wire reg_wr_stb,
	output wire [4:0] reg_wr_addr,
	output wire [7:0] reg_wr_data,
	output wire filter_restart
);
	////////////////////////////////////////////////////////////////////
	// helper functions

	// check byte over the three result bytes
	function [7:0] crc8;
		input [23:0] d;
		integer i;
		reg [7:0] c;
		begin
			c = 8'h00;
			for (i = 23; i >= 0; i = i - 1)
			begin
				if (c[7] ^ d[i])
					c = {c[6:0], 1'b0} ^ `CRDB_CRC_POLY;
				else
					c = {c[6:0], 1'b0};
			end
			crc8 = c;
		end
	endfunction

	// pick field byte by index
	function [7:0] fbyte;
		input [23:0] d;
		input [7:0] st;
		input st_on;
		input [2:0] idx;
		reg [2:0] k;
		begin
			k = idx - {2'h0, st_on};
			if (st_on && idx == 3'h0)
				fbyte = st;
			else if (k == 3'h0)
				fbyte = d[23:16];
			else if (k == 3'h1)
				fbyte = d[15:8];
			else if (k == 3'h2)
				fbyte = d[7:0];
			else
				fbyte = crc8(d);
		end
	endfunction

	// settings whose change restarts a conversion in continuous mode
	function conv_reg;
		input [4:0] a;
		begin
			conv_reg = (a >= 5'h02 && a <= 5'h07) || (a == 5'h09);
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// pin synchronisers

	reg [2:0] sclk_q;
	reg [1:0] cs_q;
	reg [1:0] din_q;
	wire sclk_rise = sclk_q[1] && !sclk_q[2];
	wire sclk_fall = !sclk_q[1] && sclk_q[2];
	wire sel = !cs_q[1];

	// two flops before use; third sclk stage only for edge finding
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_q <= 3'h0;
			cs_q <= 2'h3;
			din_q <= 2'h0;
		end
		else if (ce)
		begin
			sclk_q <= {sclk_q[1:0], sclk};
			cs_q <= {cs_q[0], cs_n};
			din_q <= {din_q[0], din};
		end
	end

	////////////////////////////////////////////////////////////////////
	// result buffer

	wire buf_valid;
	wire [RW-1:0] buf_data;
	reg [1:0] src_q;
	reg [2:0] tx_bit_q;
	wire buf_take;

	// loading waits for a byte boundary and for register reads to end
	assign buf_take = (src_q != `CRDB_SRC_REG) && (tx_bit_q == 3'h0);

	crdb_buf #(
		.W(RW)
	) u_buf (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.in_valid(conv_valid),
		.in_ready(conv_ready),
		.in_data(conv_data),
		.out_valid(buf_valid),
		.out_ready(buf_take),
		.out_data(buf_data)
	);

	wire new_res = buf_valid && buf_take;

	////////////////////////////////////////////////////////////////////
	// state

	reg [23:0] hold_q;
	reg [23:0] snap_q;
	reg [2:0] tx_byte_q;
	reg read_lock_q;
	reg out_bit_q;
	reg oe_n_q;
	reg ready_n_q;
	reg [7:0] rx_q;
	reg [2:0] rx_bit_q;
	reg [1:0] dec_q;
	reg [4:0] addr_q;
	reg [4:0] cnt_q;
	reg [4:0] rd_addr_q;
	reg [4:0] rd_cnt_q;
	reg wr_stb_q;
	reg [4:0] wr_addr_q;
	reg [7:0] wr_data_q;
	reg restart_q;

	wire [2:0] last_idx = 3'h2 + {2'h0, status_en} + {2'h0, crc_en};
	wire [7:0] rx_byte = {rx_q[6:0], din_q[1]};
	wire rx_done = sclk_fall && sel && (rx_bit_q == 3'h7);
	wire [7:0] tx_byte = (src_q == `CRDB_SRC_REG) ? reg_rd_data :
		fbyte(snap_q, status_byte, status_en, tx_byte_q);
	wire cmd_blocked = read_lock_q || (src_q == `CRDB_SRC_REG);

	assign serial_out_ready_n = out_bit_q;
	assign serial_out_oe_n = oe_n_q;
	assign result_ready_n = ready_n_q;
	assign reg_rd_addr = rd_addr_q;
	assign reg_wr_stb = wr_stb_q;
	assign reg_wr_addr = wr_addr_q;
	assign reg_wr_data = wr_data_q;
	assign filter_restart = restart_q;

	////////////////////////////////////////////////////////////////////
	// receive side and command decoding

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_q <= 8'h00;
			rx_bit_q <= 3'h0;
			dec_q <= `CRDB_DEC_CMD;
			addr_q <= 5'h00;
			cnt_q <= 5'h00;
			wr_stb_q <= 1'b0;
			wr_addr_q <= 5'h00;
			wr_data_q <= 8'h00;
			restart_q <= 1'b0;
		end
		else if (ce)
		begin
			wr_stb_q <= 1'b0;
			restart_q <= 1'b0;
			if (!sel)
			begin
				// deselect drops any half-received command
				rx_bit_q <= 3'h0;
				dec_q <= `CRDB_DEC_CMD;
			end
			else if (sclk_fall)
			begin
				rx_q <= rx_byte;
				rx_bit_q <= rx_bit_q + 3'h1;
				if (rx_done)
				begin
					case (dec_q)
					`CRDB_DEC_CMD:
					begin
						if (!cmd_blocked)
						begin
							if (rx_byte[7:5] == `CRDB_PFX_REG_READ_CMD)
							begin
								addr_q <= rx_byte[4:0];
								dec_q <= `CRDB_DEC_RCNT;
							end
							else if (rx_byte[7:5] == `CRDB_PFX_REG_WRITE_CMD)
							begin
								addr_q <= rx_byte[4:0];
								dec_q <= `CRDB_DEC_WCNT;
							end
						end
					end
					`CRDB_DEC_RCNT:
					begin
						cnt_q <= rx_byte[4:0];
						dec_q <= `CRDB_DEC_CMD;
					end
					`CRDB_DEC_WCNT:
					begin
						cnt_q <= rx_byte[4:0];
						dec_q <= `CRDB_DEC_WDAT;
					end
					`CRDB_DEC_WDAT:
					begin
						wr_stb_q <= 1'b1;
						wr_addr_q <= addr_q;
						wr_data_q <= rx_byte;
						restart_q <= continuous_mode && conv_reg(addr_q);
						addr_q <= addr_q + 5'h01;
						cnt_q <= cnt_q - 5'h01;
						if (cnt_q == 5'h00)
							dec_q <= `CRDB_DEC_CMD;
					end
					default:
						dec_q <= `CRDB_DEC_CMD;
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// transmit side, holding register and ready flags

	wire cmd_rdata = rx_done && (dec_q == `CRDB_DEC_CMD) && !cmd_blocked &&
		(rx_byte == `CRDB_OP_RDATA);
	wire cmd_rreg2 = rx_done && (dec_q == `CRDB_DEC_RCNT) &&
		(rx_byte[7:5] == `CRDB_PFX_CNT);

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hold_q <= 24'h000000;
			snap_q <= 24'h000000;
			src_q <= `CRDB_SRC_IDLE;
			tx_bit_q <= 3'h0;
			tx_byte_q <= 3'h0;
			read_lock_q <= 1'b0;
			out_bit_q <= 1'b1;
			oe_n_q <= 1'b1;
			ready_n_q <= 1'b1;
			rd_addr_q <= 5'h00;
			rd_cnt_q <= 5'h00;
		end
		else if (ce)
		begin
			oe_n_q <= !sel;
			if (new_res)
			begin
				hold_q <= buf_data[23:0];
				ready_n_q <= 1'b0;
				if (!read_lock_q)
				begin
					out_bit_q <= 1'b0;
					if (direct_mode)
					begin
						snap_q <= buf_data[23:0];
						src_q <= `CRDB_SRC_DATA;
						tx_byte_q <= 3'h0;
					end
				end
			end
			else if (!sel)
			begin
				tx_bit_q <= 3'h0;
				tx_byte_q <= 3'h0;
				read_lock_q <= 1'b0;
				src_q <= direct_mode ? `CRDB_SRC_DATA : `CRDB_SRC_IDLE;
			end
			else if (cmd_rdata)
			begin
				snap_q <= hold_q;
				src_q <= `CRDB_SRC_DATA;
				tx_byte_q <= 3'h0;
				read_lock_q <= 1'b1;
			end
			else if (cmd_rreg2)
			begin
				src_q <= `CRDB_SRC_REG;
				rd_addr_q <= addr_q;
				rd_cnt_q <= rx_byte[4:0];
			end
			else if (sclk_fall && src_q == `CRDB_SRC_DATA)
			begin
				// ready high on first falling edge
				ready_n_q <= 1'b1;
			end
			else if (sclk_rise && src_q != `CRDB_SRC_IDLE)
			begin
				// MSB first from first rising edge
				out_bit_q <= tx_byte[3'h7 - tx_bit_q];
				tx_bit_q <= tx_bit_q + 3'h1;
				if (tx_bit_q == 3'h7)
				begin
					if (src_q == `CRDB_SRC_REG)
					begin
						rd_addr_q <= rd_addr_q + 5'h01;
						rd_cnt_q <= rd_cnt_q - 5'h01;
						if (rd_cnt_q == 5'h00)
							src_q <= `CRDB_SRC_IDLE;
					end
					else if (tx_byte_q == last_idx)
					begin
						tx_byte_q <= 3'h0;
						read_lock_q <= 1'b0;
					end
					else
						tx_byte_q <= tx_byte_q + 3'h1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// *** include/crdb_consts.vh ***
`ifndef CRDB_CONSTS_VH
`define CRDB_CONSTS_VH
`define CRDB_OP_RDATA 8'h12
`define CRDB_PFX_REG_READ_CMD 3'h1
`define CRDB_PFX_REG_WRITE_CMD 3'h2
`define CRDB_PFX_CNT 3'h0
`define CRDB_CRC_POLY 8'h07
`define CRDB_SRC_IDLE 2'h0
`define CRDB_SRC_DATA 2'h1
`define CRDB_SRC_REG 2'h2
`define CRDB_DEC_CMD 2'h0
`define CRDB_DEC_RCNT 2'h1
`define CRDB_DEC_WCNT 2'h2
`define CRDB_DEC_WDAT 2'h3
`endif

// *** logic/crdb_buf.v ***
`timescale 1ns/10ps
`default_nettype none
module crdb_buf #(
	parameter W = 24
) (
	// clock and reset
	input wire clock,
	input wire rst_n,
	input wire ce,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem_q [0:1];
	reg wr_q;
	reg rd_q;
	reg [1:0] cnt_q;
	wire push;
	wire pop;

	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// two slots so a stalled drain side loses no word
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'h0;
		end
		else if (ce)
		begin
			if (push)
				wr_q <= ~wr_q;
			if (pop)
				rd_q <= ~rd_q;
			if (push && !pop)
				cnt_q <= cnt_q + 2'h1;
			else if (pop && !push)
				cnt_q <= cnt_q - 2'h1;
		end
	end

	// storage carries no reset, only data
	always @(posedge clock)
	begin
		if (ce && push)
			mem_q[wr_q] <= in_data;
	end
endmodule
`default_nettype wire

// *** verif/crdb_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module crdb_properties (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_out_ready_n,
	input wire logic serial_out_oe_n,
	input wire logic result_ready_n,
	// mode and write side
	input wire logic direct_mode,
	input wire logic continuous_mode,
	input wire logic reg_wr_stb,
	input wire logic [4:0] reg_wr_addr,
	input wire logic filter_restart
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic hit;
	// addresses whose write retunes the converter
	assign hit = reg_wr_addr inside {[5'h02:5'h07], 5'h09};
	chk_oe_release: assert property (cs_n [*5] |-> serial_out_oe_n)
		else $error("shared pin driven while deselected");
	chk_oe_drive: assert property (!cs_n [*5] |-> !serial_out_oe_n)
		else $error("shared pin not driven while selected");
	chk_restart_cause: assert property (filter_restart |-> reg_wr_stb && continuous_mode && hit)
		else $error("filter restart without a setting write");
	chk_restart_addr: assert property (reg_wr_stb && continuous_mode && hit |-> filter_restart)
		else $error("setting write without filter restart");
	chk_restart_pulse: assert property (filter_restart |=> !filter_restart)
		else $error("filter restart longer than one cycle");
	chk_wr_spacing: assert property (reg_wr_stb |=> !reg_wr_stb [*8])
		else $error("write strobes closer than one byte");
	// sync delay of the serial clock sets the window
	chk_ready_release: assert property (direct_mode && !cs_n && !result_ready_n && $fell(sclk)
		|-> ##[2:5] result_ready_n)
		else $error("ready not released on first serial fall");
	chk_pin_with_ready: assert property (!serial_out_oe_n && $fell(result_ready_n)
		|-> ##[0:1] !serial_out_ready_n)
		else $error("shared pin did not fall with ready");
	chk_ready_kept: assert property (!result_ready_n && $rose(cs_n) |=> !result_ready_n)
		else $error("ready lost on deselect");
endmodule
`default_nettype wire

// *** verif/crdb_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module crdb_host (
	// serial pins toward the device
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic so
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// one byte, msb first; din moves on the rise so the device's fall sample is safe
	task xfer(input [7:0] tx, output [7:0] rx);
		int i;
		for (i = 7; i >= 0; i--)
		begin
			sclk <= 1'b1;
			din <= tx[i];
			#200;
			sclk <= 1'b0;
			rx[i] = so;
			#200;
		end
		din <= 1'b0;
	endtask
	// select change, then a settle time for the synchroniser
	task sel(input b);
		cs_n <= b;
		#400;
	endtask
endmodule
`default_nettype wire

// *** verif/conversion_data_readback_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module conversion_data_readback_bench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic sclk, cs_n, din, so, oe_n, rdy_n, stb, fr;
	logic cv = 1'b0;
	logic dm = 1'b1;
	logic cm = 1'b1;
	logic se = 1'b1;
	logic ke = 1'b1;
	logic cr;
	logic [23:0] cd = 24'h0;
	logic [23:0] d;
	logic [7:0] sb = 8'h0;
	logic [7:0] rdd, wd, rx, wdq;
	logic [4:0] ra, wa, waq;
	logic [7:0] cmd [4] = '{default: 8'h00};
	int errors = 0;
	int num_checks = 0;
	int i;
	// 20 MHz clock
	always #25 clock = ~clock;
	// register file stand-in, every lsb set
	assign rdd = {ra, 3'h5};
	// latch the last register write
	always @(posedge clock)
		if (stb === 1'b1)
		begin
			waq <= wa;
			wdq <= wd;
		end
	crdb_top u_crdb_top (.clock(clock), .rst_n(rst_n), .ce(1'b1), .sclk(sclk), .cs_n(cs_n),
		.din(din), .serial_out_ready_n(so), .serial_out_oe_n(oe_n), .result_ready_n(rdy_n),
		.conv_valid(cv), .conv_ready(cr), .conv_data(cd), .direct_mode(dm),
		.continuous_mode(cm), .status_en(se), .crc_en(ke), .status_byte(sb),
		.reg_rd_addr(ra), .reg_rd_data(rdd), .reg_wr_stb(stb), .reg_wr_addr(wa),
		.reg_wr_data(wd), .filter_restart(fr));
	crdb_host u_crdb_host (.sclk(sclk), .cs_n(cs_n), .din(din), .so(so));
	task check(input [23:0] got, input [23:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// check byte over the 24 result bits
	function [7:0] crc(input [23:0] v);
		int k;
		crc = 8'h00;
		for (k = 23; k >= 0; k--)
			crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ v[k]) ? 8'h07 : 8'h00);
	endfunction
	// byte k of the repeating field
	function [7:0] fld(input int k);
		int j;
		j = k % (3 + se + ke) - se;
		fld = (j < 0) ? sb : (j < 3) ? d[8 * (2 - j) +: 8] : crc(d);
	endfunction
	// hand one result over, then wait for ready under a bound
	task push;
		d = $urandom;
		@(posedge clock);
		cv <= 1'b1;
		cd <= d;
		@(posedge clock);
		while (cr !== 1'b1)
			@(posedge clock);
		cv <= 1'b0;
		repeat (40) if (rdy_n !== 1'b0) @(posedge clock);
	endtask
	// read n bytes, sending cmd bytes first
	task rdn(input int n);
		int k;
		for (k = 0; k < n; k++)
		begin
			u_crdb_host.xfer(k < 4 ? cmd[k] : 8'h00, rx);
			check(24'(rx), 24'(fld(k)));
		end
	endtask
	// main sequence
	initial
	begin
		i = $urandom(62899);
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		u_crdb_host.sel(1'b0);
		// each field read before the next result
		for (i = 0; i < 4; i++)
		begin
			sb <= $urandom;
			se <= (i == 0) | $urandom;
			ke <= (i == 0) | $urandom;
			push;
			check(24'(so), 24'h0);
			rdn(2 * (3 + se + ke));
			check(24'(rdy_n), 24'h1);
		end
		se <= 1'b0;
		ke <= 1'b0;
		cmd = '{8'h42, 8'h00, 8'h5A, 8'h00};
		push;
		rdn(6);
		check(24'({waq, wdq}), 24'h0025A);
		cmd = '{default: 8'h00};
		dm <= 1'b0;
		push;
		// a write sent inside a locked read must be ignored
		cmd = '{8'h43, 8'h00, 8'h11, 8'h00};
		u_crdb_host.xfer(8'h12, rx);
		rdn(3);
		check(24'({waq, wdq}), 24'h0025A);
		cmd = '{default: 8'h00};
		u_crdb_host.xfer(8'h25, rx);
		u_crdb_host.xfer(8'h00, rx);
		u_crdb_host.xfer(8'h00, rx);
		check(24'(rx), 24'h2D);
		repeat (8) @(posedge clock);
		check(24'(so), 24'h1);
		// a pending result must survive deselect on the dedicated pin
		push;
		u_crdb_host.sel(1'b1);
		check(24'(oe_n), 24'h1);
		check(24'(rdy_n), 24'h0);
		conclude;
	end
	// watchdog well past the expected run
	initial
	begin
		#400000;
		errors++;
		conclude;
	end
endmodule
bind crdb_top crdb_properties u_crdb_properties (.clock(clock), .rst_n(rst_n), .sclk(sclk),
	.cs_n(cs_n), .serial_out_ready_n(serial_out_ready_n), .serial_out_oe_n(serial_out_oe_n),
	.result_ready_n(result_ready_n), .direct_mode(direct_mode),
	.continuous_mode(continuous_mode), .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
	.filter_restart(filter_restart));
`default_nettype wire
